// ===== rtl/oag_core.v
// operand address generator for the 8-bit core
// Overview of operation
// - short direct reaches only FE20H..FF1FH
// - decode window into RAM or SFR
// - operand 20H..FFH clears address bit 8
// - operand 00H..1FH sets address bit 8
// - SFR mode forms FF00H..FFFFH addresses
// - 3-bit field picks one of eight bytes
// - byte set X..H, pair set AX..HL
// - indirect uses full DE or HL
// - based adds zero-extended byte, wraps
// - stack pointer used for stack operations
// - opcode 10101010 is push of DE
`timescale 1ns/1ns
`include "oag_defs.vh"
module oag_core #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  reset_n,
  // decoded instruction fields
  input  wire [`OAG_MODE_W-1:0] mode_select,
  input  wire [7:0]            operand_byte,
  input  wire [15:0]           operand_word,
  input  wire [2:0]            byte_reg_code,
  input  wire [1:0]            register_pair_operand,
  input  wire                  indirect_use_base,
  input  wire                  short_pair_access,
  input  wire [7:0]            opcode,
  // register contents
  input  wire [15:0]           pair_ax,
  input  wire [15:0]           pair_bc,
  input  wire [15:0]           second_indirect_pair,
  input  wire [15:0]           base_pair,
  input  wire [15:0]           stack_pointer,
  // generated address and decode
  output reg  [ADDR_W-1:0]     effective_address,
  output reg                   address_valid,
  output reg  [1:0]            address_region,
  output reg                   register_operand,
  output wire [7:0]            byte_reg_value,
  output wire [15:0]           pair_reg_value,
  output reg                   stack_access,
  output reg                   push_second_pair,
  output reg                   short_pair_fault,
  // registered copy of the last valid address
  output reg  [ADDR_W-1:0]     last_address
);
  // packed register file for the selector
  wire [63:0] pair_bus;
  // bit 8 of a short direct address
  reg         short_bit8;
  // based sum, carry dropped by width
  wire [15:0] based_sum;
  // stack use request from the stack mode code or the push DE opcode
  reg         stack_request;

  assign pair_bus = {base_pair, second_indirect_pair, pair_bc, pair_ax};

  // register selection is purely combinational
  // byte register select
  oag_reg_select u_sel (
    .pair_bus   (pair_bus),
    .byte_code  (byte_reg_code),
    .pair_code  (register_pair_operand),
    .byte_value (byte_reg_value),
    .pair_value (pair_reg_value)
  );

  always @* begin
    short_bit8 = (operand_byte < `OAG_SHORT_SPLIT);
  end

  assign based_sum = base_pair + {8'h00, operand_byte};

  always @* begin
    push_second_pair = (opcode == `OAG_OP_PUSH_DE);
  end

  // push DE gives stack addressing only when no mode code is selected
  always @* begin
    stack_request = (mode_select == `OAG_MODE_STACK) || push_second_pair;
  end

  // address formation, same cycle as the fields
  // combinational address path
  always @* begin
    effective_address = {ADDR_W{1'b0}};
    address_valid     = 1'b1;
    register_operand  = 1'b0;
    stack_access      = 1'b0;
    case (mode_select)
      `OAG_MODE_SHORT: begin
        effective_address = {`OAG_SHORT_UPPER, short_bit8, operand_byte};
      end
      `OAG_MODE_SFR: begin
        effective_address = {`OAG_SFR_UPPER, operand_byte};
      end
      // operand is a register, no memory address
      `OAG_MODE_REG: begin
        address_valid    = 1'b0;
        register_operand = 1'b1;
      end
      `OAG_MODE_INDIRECT: begin
        effective_address = indirect_use_base ? base_pair : second_indirect_pair;
      end
      `OAG_MODE_BASED: begin
        effective_address = based_sum;
      end
      `OAG_MODE_STACK: begin
        effective_address = stack_pointer;
        stack_access      = 1'b1;
      end
      `OAG_MODE_DIRECT: begin
        effective_address = operand_word;
      end
      default: begin
        // the push opcode still needs its stack address
        if (stack_request) begin
          effective_address = stack_pointer;
          stack_access      = 1'b1;
        end else begin
          address_valid = 1'b0;
        end
      end
    endcase
  end

  // region decode of the generated address
  // RAM versus SFR split
  always @* begin
    if (!address_valid) begin
      address_region = `OAG_REG_NONE;
    end else if (effective_address >= `OAG_SHORT_LO && effective_address <= `OAG_RAM_HI) begin
      address_region = `OAG_REG_RAM;
    end else if (effective_address >= `OAG_SFR_SHORT_LO) begin
      address_region = `OAG_REG_SFR;
    end else begin
      address_region = `OAG_REG_OTHER;
    end
  end

  // odd pair address in short mode is flagged, not corrected;
  // keeping it even is the decoder's duty
  // even pair operand check
  always @* begin
    short_pair_fault = (mode_select == `OAG_MODE_SHORT) && short_pair_access &&
                       operand_byte[0];
  end

  // hold the last valid address for debug and multi-cycle accesses
  always @(posedge clk) begin
    if (!reset_n) begin
      last_address <= {ADDR_W{1'b0}};
    end else if (address_valid) begin
      last_address <= effective_address;
    end
  end
endmodule

// ===== rtl/oag_defs.vh
// constants for the operand address generator
`ifndef OAG_DEFS_VH
`define OAG_DEFS_VH
// addressing mode select codes (one-hot)
`define OAG_MODE_W         7
`define OAG_MODE_NONE      7'h00
`define OAG_MODE_SHORT     7'h01
`define OAG_MODE_SFR       7'h02
`define OAG_MODE_REG       7'h04
`define OAG_MODE_INDIRECT  7'h08
`define OAG_MODE_BASED     7'h10
`define OAG_MODE_STACK     7'h20
`define OAG_MODE_DIRECT    7'h40
// short direct window
`define OAG_SHORT_LO       16'hfe20
`define OAG_SHORT_HI       16'hff1f
`define OAG_SHORT_UPPER    7'h7f
`define OAG_SHORT_SPLIT    8'h20
`define OAG_RAM_HI         16'hfeff
`define OAG_SFR_SHORT_LO   16'hff00
// special function register page
`define OAG_SFR_UPPER      8'hff
// byte register codes
`define OAG_R_X            3'h0
`define OAG_R_A            3'h1
`define OAG_R_C            3'h2
`define OAG_R_B            3'h3
`define OAG_R_E            3'h4
`define OAG_R_D            3'h5
`define OAG_R_L            3'h6
`define OAG_R_H            3'h7
// pair codes
`define OAG_RP_AX          2'h0
`define OAG_RP_BC          2'h1
`define OAG_RP_DE          2'h2
`define OAG_RP_HL          2'h3
// push of the second indirect pair
`define OAG_OP_PUSH_DE     8'haa
// region codes
`define OAG_REG_NONE       2'h0
`define OAG_REG_RAM        2'h1
`define OAG_REG_SFR        2'h2
`define OAG_REG_OTHER      2'h3
`endif

// ===== rtl/oag_reg_select.v
// byte and pair register selection from the register specify codes
`timescale 1ns/1ns
`include "oag_defs.vh"
module oag_reg_select (
  // register file contents, pair 0 in the low 16 bits
  input  wire [63:0] pair_bus,
  // selection codes
  input  wire [2:0]  byte_code,
  input  wire [1:0]  pair_code,
  // selected values
  output reg  [7:0]  byte_value,
  output reg  [15:0] pair_value
);
  // byte code n is the low byte for even n and high byte for odd n
  // register set order
  always @* begin
    byte_value = pair_bus[{byte_code, 3'h0} +: 8];
  end
  // pair code picks one 16-bit slot
  // pair code order
  always @* begin
    pair_value = pair_bus[{pair_code, 4'h0} +: 16];
  end
endmodule

// ===== verif/oag_regs_model.sv
// register file model feeding the address generator
`timescale 1ns/1ns
module oag_regs_model (
  // value chosen by the bench
  input  wire [15:0] seed,
  // register pairs
  output wire [15:0] r_ax,
  output wire [15:0] r_bc,
  output wire [15:0] r_sec,
  output wire [15:0] r_base,
  output wire [15:0] r_sp
);
  // distinct pair contents so a wrong pick shows
  assign r_ax   = seed ^ 16'h0f0f;
  assign r_bc   = seed ^ 16'hf0f0;
  assign r_sec  = ~seed;
  assign r_base = seed;
  assign r_sp   = {8'hfe, seed[7:6], 1'b1, seed[4:0]};
endmodule

// ===== verif/oag_core_asserts.sv
// assertions on the address generator ports
`timescale 1ns/1ns
module oag_core_asserts #(
  parameter ADDR_W = 16
) (
  // clock, reset and fields
  input wire              clk,
  input wire              reset_n,
  input wire [6:0]        mode_select,
  input wire [7:0]        operand_byte,
  input wire              indirect_use_base,
  input wire [7:0]        opcode,
  input wire [15:0]       second_indirect_pair,
  input wire [15:0]       base_pair,
  input wire [15:0]       stack_pointer,
  // outputs
  input wire [ADDR_W-1:0] effective_address,
  input wire              address_valid,
  input wire [1:0]        address_region,
  input wire              register_operand,
  input wire              stack_access,
  input wire              push_second_pair,
  input wire [ADDR_W-1:0] last_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a cycle with a usable address
  sequence s_valid;
    address_valid;
  endsequence
  // short direct mode selected
  sequence s_short;
    mode_select == 7'h01;
  endsequence
  short_map_a: assert property (s_short |-> effective_address ==
    {7'h7f, operand_byte < 8'h20, operand_byte}) else $error("short address");
  short_region_a: assert property (s_short |-> address_region ==
    ((operand_byte < 8'h20) ? 2'h2 : 2'h1)) else $error("short region");
  sfr_page_a: assert property (mode_select == 7'h02 |->
    effective_address == {8'hff, operand_byte}) else $error("sfr address");
  reg_mode_a: assert property (mode_select == 7'h04 |->
    register_operand && !address_valid) else $error("register mode");
  indirect_pair_a: assert property (mode_select == 7'h08 |-> effective_address ==
    (indirect_use_base ? base_pair : second_indirect_pair)) else $error("indirect");
  based_wrap_a: assert property (mode_select == 7'h10 |->
    effective_address == base_pair + {8'h00, operand_byte}) else $error("based sum");
  stack_use_a: assert property (mode_select == 7'h20 |->
    stack_access && effective_address == stack_pointer) else $error("stack");
  push_code_a: assert property (opcode == 8'haa |-> push_second_pair)
    else $error("push code");
  last_keep_a: assert property (s_valid |=>
    last_address == $past(effective_address)) else $error("last address");
endmodule
bind oag_core oag_core_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== verif/tb_top.sv
// self-checking bench for the address generator
`timescale 1ns/1ns
module tb_top;
  reg         clk = 0;
  reg         reset_n = 0;
  reg  [6:0]  mode = 0;
  reg  [7:0]  op = 0;
  reg  [7:0]  opc = 0;
  reg  [2:0]  code = 0;
  reg         ub = 0;
  reg         spa = 0;
  reg  [15:0] seed = 16'h1234;
  reg  [15:0] w;
  wire [15:0] r_ax, r_bc, r_sec, r_base, r_sp, ea, lst, pv;
  wire [7:0]  bv;
  wire [1:0]  rg;
  wire        av, ro, sa, ps, pf;
  integer     error_cnt = 0;
  integer     checks_done = 0;
  integer     i;
  // 25 MHz core clock
  always #20 clk = ~clk;
  oag_regs_model u_regs (.seed(seed), .r_ax(r_ax), .r_bc(r_bc), .r_sec(r_sec),
    .r_base(r_base), .r_sp(r_sp));
  oag_core u_dut (.clk(clk), .reset_n(reset_n), .mode_select(mode), .operand_byte(op),
    .operand_word(seed), .byte_reg_code(code), .register_pair_operand(code[1:0]),
    .indirect_use_base(ub), .short_pair_access(spa), .opcode(opc), .pair_ax(r_ax),
    .pair_bc(r_bc), .second_indirect_pair(r_sec), .base_pair(r_base),
    .stack_pointer(r_sp), .effective_address(ea), .address_valid(av),
    .address_region(rg), .register_operand(ro), .byte_reg_value(bv),
    .pair_reg_value(pv), .stack_access(sa), .push_second_pair(ps),
    .short_pair_fault(pf), .last_address(lst));
  // compare and count
  task chk(input [15:0] g, input [15:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // fields change on the falling edge, then settle
  task set(input [6:0] m, input [7:0] o);
    begin
      @(negedge clk);
      mode = m;
      op = o;
      #1;
    end
  endtask
  // short window ends and the split point
  task t_short;
    begin
      spa = 1; // odd operand only to see the flag
      set(7'h01, 8'h1f);
      chk(ea, 16'hff1f);
      chk({14'h0, rg}, 16'h2);
      chk({15'h0, pf}, 16'h1);
      set(7'h01, 8'h20);
      chk(ea, 16'hfe20);
      chk({15'h0, pf}, 16'h0);
      chk({14'h0, rg}, 16'h1);
      set(7'h01, 8'h00);
      chk(ea, 16'hff00);
      set(7'h02, 8'h80); // page above the short window
      chk(ea, 16'hff80);
    end
  endtask
  // every byte code and pair code
  task t_reg;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        code = i;
        set(7'h04, 8'h00);
        w = (i < 2) ? r_ax : (i < 4) ? r_bc : (i < 6) ? r_sec : r_base;
        chk({8'h0, bv}, {8'h0, i[0] ? w[15:8] : w[7:0]});
        w = (i % 4 == 0) ? r_ax : (i % 4 == 1) ? r_bc : (i % 4 == 2) ? r_sec : r_base;
        chk(pv, w);
        chk({14'h0, ro, av}, 16'h2);
      end
    end
  endtask
  // indirect, wrapping base sum, stack, push code
  task t_mem;
    begin
      ub = 1;
      set(7'h08, 8'h00);
      chk(ea, r_base);
      ub = 0;
      set(7'h08, 8'h00);
      chk(ea, r_sec);
      seed = 16'hffff;
      set(7'h10, 8'h02);
      chk(ea, 16'h0001);
      chk({14'h0, rg}, 16'h3);
      @(posedge clk);
      #1;
      chk(lst, 16'h0001);
      set(7'h20, 8'h00);
      chk(ea, r_sp);
      opc = 8'haa;
      set(7'h00, 8'h00);
      chk({14'h0, sa, ps}, 16'h3);
      chk({15'h0, av}, 16'h1);
      opc = 8'h00;
      set(7'h40, 8'h00);
      chk(ea, seed);
      set(7'h03, 8'h00);
      chk({13'h0, sa, rg, av}, 16'h0);
    end
  endtask
  // verdict
  task test_done;
    begin
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1;
    #1;
    chk(lst, 16'h0000);
    t_short;
    t_reg;
    t_mem;
    test_done;
  end
  // hang guard
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    test_done;
  end
endmodule
